// ===== src/uart_eff_defs.vh
`ifndef UART_EFF_DEFS_VH
`define UART_EFF_DEFS_VH

// Register indices on the internal register port
`define IDX_LINE_CONTROL 5'h00
`define IDX_INTERRUPT_ENABLE 5'h01
`define IDX_FIFO_CONTROL 5'h02
`define IDX_MODEM_CONTROL 5'h03
`define IDX_INTERRUPT_STATUS 5'h04
`define IDX_MODEM_STATUS 5'h05
`define IDX_SCRATCHPAD 5'h06
`define IDX_TRIGGER_CONTROL 5'h07
`define IDX_TRIGGER_LEVEL 5'h08
`define IDX_DIVISOR_LOW 5'h09
`define IDX_DIVISOR_HIGH 5'h0a
`define IDX_FRACTIONAL_DIVISOR 5'h0b
`define IDX_ENHANCED_FEATURE 5'h0c
`define IDX_RESUME_CHAR_ONE 5'h0d
`define IDX_RESUME_CHAR_TWO 5'h0e
`define IDX_PAUSE_CHAR_ONE 5'h0f
`define IDX_PAUSE_CHAR_TWO 5'h10
`define IDX_GPIO_CONTROL 5'h11
`define IDX_LINE_STATUS 5'h12

// Reset values
`define RST_LINE_CONTROL 8'h1d
`define RST_INTERRUPT_ENABLE 8'h00
`define RST_FIFO_CONTROL 8'h00
`define RST_MODEM_CONTROL 8'h00
`define RST_SCRATCHPAD 8'hff
`define RST_TRIGGER_CONTROL 8'h0f
`define RST_TRIGGER_LEVEL 8'h00
`define RST_DIVISOR_LOW 8'h01
`define RST_DIVISOR_HIGH 8'h00
`define RST_FRACTIONAL_DIVISOR 8'h00
`define RST_ENHANCED_FEATURE 8'h00
`define RST_FLOW_CHAR 8'h00
`define RST_GPIO_CONTROL 8'h00

// Bits that only change while the enhanced enable is set
`define MASK_IER_ENH 8'hf0
`define MASK_FCR_ENH 8'h30
`define MASK_MCR_ENH 8'he4
`define MASK_ALL_ENH 8'hff

// Enhanced feature control fields
`define EFR_ENH_EN 4
`define EFR_SPECIAL_EN 5
`define EFR_AUTO_RTS 6
`define EFR_AUTO_CTS 7
`define RX_SEL_PAIR_ONE 2'b10
`define RX_SEL_PAIR_TWO 2'b01

// Other field positions
`define IER_RX_DATA 0
`define IER_SPECIAL 5
`define MCR_DTR 0
`define MCR_RTS 1
`define IOC_SOFT_RESET 3

// Receive trigger levels picked by fifo control bits 7:6
`define RX_TRIG_SEL0 7'd8
`define RX_TRIG_SEL1 7'd16
`define RX_TRIG_SEL2 7'd56
`define RX_TRIG_SEL3 7'd60

`endif

// ===== src/special_char_detect.v
`timescale 1ns/1ps
module special_char_detect (
  // Clock and reset
  input wire clk_i,
  input wire reset_i,
  // Received character from the receiver
  input wire char_valid_i,
  input wire [7:0] char_i,
  // Configuration
  input wire special_en_i,
  input wire [1:0] rx_sel_i,
  input wire [7:0] match_char_i,
  // Results
  output reg store_o,
  output reg [7:0] store_data_o,
  output reg special_o,
  output reg xoff_o
);
`include "uart_eff_defs.vh"

  wire match;
  wire swallow;

  // Bit 0 of the register lines up with the first received bit
  assign match = char_valid_i && special_en_i && (char_i == match_char_i); // RULE5
  assign swallow = match && (rx_sel_i == `RX_SEL_PAIR_TWO); // RULE7

  always @(posedge clk_i) begin
    if (reset_i) begin
      store_o <= 1'b0;
      store_data_o <= 8'h00;
      special_o <= 1'b0;
      xoff_o <= 1'b0;
    end else begin
      // Pair one selection falls through to normal storing
      store_o <= char_valid_i && !swallow; // RULE6
      store_data_o <= char_i;
      special_o <= match; // RULE5
      xoff_o <= swallow; // RULE7
    end
  end
endmodule

// ===== src/auto_rts_ctrl.v
`timescale 1ns/1ps
module auto_rts_ctrl (
  // Clock and reset
  input wire clk_i,
  input wire reset_i,
  // Configuration
  input wire auto_en_i,
  input wire sw_rts_i,
  input wire [6:0] halt_level_i,
  input wire [6:0] resume_level_i,
  // Receive fill
  input wire [6:0] rx_fill_i,
  // Pin
  output reg rts_n_o
);

  reg halted_q;
  reg halted_d;

  always @* begin
    halted_d = halted_q;
    if (!auto_en_i || !sw_rts_i) begin
      halted_d = 1'b0;
    end else if (rx_fill_i >= halt_level_i) begin
      halted_d = 1'b1; // RULE8
    end else if (rx_fill_i < resume_level_i) begin
      halted_d = 1'b0; // RULE9
    end
  end

  always @(posedge clk_i) begin
    if (reset_i) begin
      halted_q <= 1'b0;
      rts_n_o <= 1'b1; // RULE18
    end else begin
      halted_q <= halted_d;
      // Auto control only acts once software holds the line asserted
      if (auto_en_i) begin
        rts_n_o <= !sw_rts_i || halted_d; // RULE10
      end else begin
        rts_n_o <= !sw_rts_i; // RULE11
      end
    end
  end
endmodule

// ===== src/uart_enhanced_feature_flow_control.v
`timescale 1ns/1ps
// What this block does
// RULE1 - Enhanced bits accept writes only while the enhanced enable bit is one.
// RULE2 - Clearing the enable freezes enhanced bits until it is set again.
// RULE3 - Reset clears enhanced bits and fractional divisor for legacy behaviour; trigger control still resets to 0x0f.
// RULE4 - Software should normally leave the enhanced enable bit set.
// RULE5 - Special detect compares each received character with pause char two, flags it.
// RULE6 - Pair one receive selection keeps flow control and detection both normal.
// RULE7 - Pair two selection drops matching character, raises pause and special interrupts.
// RULE8 - Auto request-to-send interrupts at trigger level, deasserts at halt level.
// RULE9 - Auto request-to-send reasserts when fill drops below resume level.
// RULE10 - Auto request-to-send acts only after software asserted the line.
// RULE11 - Without hardware flow control request-to-send follows its software bit.
// RULE12 - Auto clear-to-send stops transmit while input high; enables default off.
// RULE13 - Four read/write flow characters: resume one, two, pause one, two.
// RULE14 - Power-up loads divisor high byte 0x00 and low byte 0x01.
// RULE15 - Divisor, scratchpad, flow characters reset only at power-up.
// RULE16 - Reset clears modem status deltas, loads upper bits with inverted inputs.
// RULE17 - Flow selections return to zero before a new selection is written.
// RULE18 - Reset drives transmit, request-to-send, terminal-ready and interrupt outputs high.
module uart_enhanced_feature_flow_control #(
  parameter FILL_W = 7
) (
  // Clock and resets
  input wire clk_i,
  input wire reset_i,
  input wire por_i,
  // Register port from the serial slave front end
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [4:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  output reg [7:0] reg_rdata_o,
  // Receiver and receive FIFO
  input wire rx_char_valid_i,
  input wire [7:0] rx_char_i,
  input wire [FILL_W-1:0] rx_fill_i,
  output wire rx_store_o,
  output wire [7:0] rx_store_data_o,
  output wire xoff_event_o,
  // Transmitter
  input wire tx_serial_i,
  input wire tx_empty_i,
  input wire thr_empty_i,
  output reg tx_o,
  output reg tx_enable_o,
  // Modem pins
  input wire cts_n_i,
  input wire dsr_n_i,
  input wire ri_n_i,
  input wire cd_n_i,
  output wire rts_n_o,
  output reg dtr_n_o,
  // Interrupt and configuration out
  output reg irq_n_o,
  output reg soft_reset_o,
  output reg [15:0] divisor_o,
  output reg [7:0] fractional_divisor_o
);
`include "uart_eff_defs.vh"

  reg [7:0] line_control_reg_q;
  reg [7:0] interrupt_enable_reg_q;
  reg [7:0] fifo_control_reg_q;
  reg [7:0] modem_control_reg_q;
  reg [7:0] scratchpad_reg_q;
  reg [7:0] trigger_control_reg_q;
  reg [7:0] trigger_level_reg_q;
  reg [7:0] divisor_low_byte_q;
  reg [7:0] divisor_high_byte_q;
  reg [7:0] fractional_divisor_reg_q;
  reg [7:0] enhanced_feature_control_q;
  reg [7:0] flow_resume_char_one_q;
  reg [7:0] flow_resume_char_two_q;
  reg [7:0] flow_pause_char_one_q;
  reg [7:0] flow_pause_char_two_q;
  reg [7:0] gpio_control_reg_q;
  reg special_flag_q;
  reg xoff_flag_q;
  reg [3:0] modem_delta_q;
  reg [3:0] modem_prev_q;
  reg [3:0] modem_meta_q;
  reg [3:0] modem_sync_q;
  reg soft_req_q;
  reg [7:0] rdata_d;

  wire any_reset;
  wire enh_en;
  wire wr_hit;
  wire [3:0] modem_level;
  wire [FILL_W-1:0] rx_trigger;
  wire rx_trig_hit;
  wire det_special;
  wire irq_d;

  // Merge a write, keeping masked bits frozen while not enabled
  function [7:0] gated_write;
    input [7:0] old_val;
    input [7:0] new_val;
    input [7:0] mask;
    input en;
    begin
      if (en) begin
        gated_write = new_val;
      end else begin
        gated_write = (new_val & ~mask) | (old_val & mask);
      end
    end
  endfunction

  // Nibble times four as a FIFO level
  function [FILL_W-1:0] level_x4;
    input [3:0] nib;
    begin
      level_x4 = {{(FILL_W-6){1'b0}}, nib, 2'b00};
    end
  endfunction

  function [FILL_W-1:0] fcr_trigger;
    input [1:0] sel;
    begin
      case (sel)
        2'd0: fcr_trigger = `RX_TRIG_SEL0;
        2'd1: fcr_trigger = `RX_TRIG_SEL1;
        2'd2: fcr_trigger = `RX_TRIG_SEL2;
        default: fcr_trigger = `RX_TRIG_SEL3;
      endcase
    end
  endfunction

  assign any_reset = reset_i || por_i || soft_req_q;
  assign enh_en = enhanced_feature_control_q[`EFR_ENH_EN];
  assign wr_hit = reg_wr_i;
  assign modem_level = ~modem_sync_q;
  assign rx_trigger = (trigger_level_reg_q[7:4] != 4'h0) ? level_x4(trigger_level_reg_q[7:4]) :
    fcr_trigger(fifo_control_reg_q[7:6]);
  assign rx_trig_hit = rx_fill_i >= rx_trigger;

  // Channel registers loaded with their reset values by any reset
  always @(posedge clk_i) begin
    if (any_reset) begin
      line_control_reg_q <= `RST_LINE_CONTROL;
      interrupt_enable_reg_q <= `RST_INTERRUPT_ENABLE; // RULE3
      fifo_control_reg_q <= `RST_FIFO_CONTROL; // RULE3
      modem_control_reg_q <= `RST_MODEM_CONTROL; // RULE3
      trigger_control_reg_q <= `RST_TRIGGER_CONTROL;
      trigger_level_reg_q <= `RST_TRIGGER_LEVEL;
      fractional_divisor_reg_q <= `RST_FRACTIONAL_DIVISOR; // RULE3
      enhanced_feature_control_q <= `RST_ENHANCED_FEATURE; // RULE12
      gpio_control_reg_q <= `RST_GPIO_CONTROL;
    end else if (wr_hit) begin
      case (reg_addr_i)
        `IDX_LINE_CONTROL: begin
          line_control_reg_q <= reg_wdata_i;
        end
        `IDX_INTERRUPT_ENABLE: begin
          interrupt_enable_reg_q <= gated_write(interrupt_enable_reg_q, reg_wdata_i, `MASK_IER_ENH, enh_en); // RULE1
        end
        `IDX_FIFO_CONTROL: begin
          fifo_control_reg_q <= gated_write(fifo_control_reg_q, reg_wdata_i, `MASK_FCR_ENH, enh_en); // RULE1
        end
        `IDX_MODEM_CONTROL: begin
          modem_control_reg_q <= gated_write(modem_control_reg_q, reg_wdata_i, `MASK_MCR_ENH, enh_en); // RULE2
        end
        `IDX_TRIGGER_CONTROL: begin
          trigger_control_reg_q <= gated_write(trigger_control_reg_q, reg_wdata_i, `MASK_ALL_ENH, enh_en); // RULE1
        end
        `IDX_TRIGGER_LEVEL: begin
          trigger_level_reg_q <= gated_write(trigger_level_reg_q, reg_wdata_i, `MASK_ALL_ENH, enh_en); // RULE1
        end
        `IDX_FRACTIONAL_DIVISOR: begin
          fractional_divisor_reg_q <= gated_write(fractional_divisor_reg_q, reg_wdata_i, `MASK_ALL_ENH, enh_en); // RULE2
        end
        `IDX_ENHANCED_FEATURE: begin
          // Selection changes are expected to pass through zero first
          enhanced_feature_control_q <= reg_wdata_i; // RULE17
        end
        `IDX_GPIO_CONTROL: begin
          gpio_control_reg_q <= {reg_wdata_i[7:4], 1'b0, reg_wdata_i[2:0]};
        end
        default: begin
        end
      endcase
    end
  end

  // Power-up only storage; pin and software resets leave it alone
  always @(posedge clk_i) begin
    if (por_i) begin
      divisor_low_byte_q <= `RST_DIVISOR_LOW; // RULE14
      divisor_high_byte_q <= `RST_DIVISOR_HIGH; // RULE14
      scratchpad_reg_q <= `RST_SCRATCHPAD; // RULE15
      flow_resume_char_one_q <= `RST_FLOW_CHAR; // RULE15
      flow_resume_char_two_q <= `RST_FLOW_CHAR;
      flow_pause_char_one_q <= `RST_FLOW_CHAR;
      flow_pause_char_two_q <= `RST_FLOW_CHAR;
    end else if (wr_hit) begin
      case (reg_addr_i)
        `IDX_DIVISOR_LOW: divisor_low_byte_q <= reg_wdata_i;
        `IDX_DIVISOR_HIGH: divisor_high_byte_q <= reg_wdata_i;
        `IDX_SCRATCHPAD: scratchpad_reg_q <= reg_wdata_i;
        `IDX_RESUME_CHAR_ONE: flow_resume_char_one_q <= reg_wdata_i; // RULE13
        `IDX_RESUME_CHAR_TWO: flow_resume_char_two_q <= reg_wdata_i; // RULE13
        `IDX_PAUSE_CHAR_ONE: flow_pause_char_one_q <= reg_wdata_i; // RULE13
        `IDX_PAUSE_CHAR_TWO: flow_pause_char_two_q <= reg_wdata_i; // RULE13
        default: begin
        end
      endcase
    end
  end

  // Software reset pulse; the bit itself never reads back as one
  always @(posedge clk_i) begin
    if (reset_i || por_i || soft_req_q) begin
      soft_req_q <= 1'b0;
    end else begin
      soft_req_q <= wr_hit && (reg_addr_i == `IDX_GPIO_CONTROL) && reg_wdata_i[`IOC_SOFT_RESET];
    end
  end

  // Modem inputs pass two flops; order cd, ri, dsr, cts
  always @(posedge clk_i) begin
    modem_meta_q <= {cd_n_i, ri_n_i, dsr_n_i, cts_n_i};
    modem_sync_q <= modem_meta_q;
  end

  // Deltas: a change in the read cycle survives the clear
  always @(posedge clk_i) begin
    if (any_reset) begin
      modem_delta_q <= 4'h0; // RULE16
      modem_prev_q <= modem_sync_q; // RULE16
    end else begin
      modem_prev_q <= modem_sync_q;
      if (reg_rd_i && (reg_addr_i == `IDX_MODEM_STATUS)) begin
        modem_delta_q <= modem_sync_q ^ modem_prev_q;
      end else begin
        modem_delta_q <= modem_delta_q | (modem_sync_q ^ modem_prev_q);
      end
    end
  end

  special_char_detect u_detect (
    .clk_i(clk_i),
    .reset_i(any_reset),
    .char_valid_i(rx_char_valid_i),
    .char_i(rx_char_i),
    .special_en_i(enhanced_feature_control_q[`EFR_SPECIAL_EN]),
    .rx_sel_i(enhanced_feature_control_q[1:0]),
    .match_char_i(flow_pause_char_two_q),
    .store_o(rx_store_o),
    .store_data_o(rx_store_data_o),
    .special_o(det_special),
    .xoff_o(xoff_event_o)
  );

  auto_rts_ctrl u_rts (
    .clk_i(clk_i),
    .reset_i(any_reset),
    .auto_en_i(enhanced_feature_control_q[`EFR_AUTO_RTS]),
    .sw_rts_i(modem_control_reg_q[`MCR_RTS]),
    .halt_level_i(level_x4(trigger_control_reg_q[3:0])),
    .resume_level_i(level_x4(trigger_control_reg_q[7:4])),
    .rx_fill_i(rx_fill_i),
    .rts_n_o(rts_n_o)
  );

  // Status flags clear on status read, new event wins
  always @(posedge clk_i) begin
    if (any_reset) begin
      special_flag_q <= 1'b0; // RULE3
      xoff_flag_q <= 1'b0;
    end else begin
      if (det_special) begin
        special_flag_q <= 1'b1; // RULE5
      end else if (reg_rd_i && (reg_addr_i == `IDX_INTERRUPT_STATUS)) begin
        special_flag_q <= 1'b0;
      end
      if (xoff_event_o) begin
        xoff_flag_q <= 1'b1; // RULE7
      end else if (reg_rd_i && (reg_addr_i == `IDX_INTERRUPT_STATUS)) begin
        xoff_flag_q <= 1'b0;
      end
    end
  end

  // Trigger interrupt only applies with auto request-to-send enabled
  assign irq_d = (enhanced_feature_control_q[`EFR_AUTO_RTS] && interrupt_enable_reg_q[`IER_RX_DATA]
    && rx_trig_hit) || (special_flag_q && interrupt_enable_reg_q[`IER_SPECIAL]) || xoff_flag_q; // RULE8

  always @* begin
    rdata_d = 8'h00;
    case (reg_addr_i)
      `IDX_LINE_CONTROL: rdata_d = line_control_reg_q;
      `IDX_INTERRUPT_ENABLE: rdata_d = interrupt_enable_reg_q;
      `IDX_FIFO_CONTROL: rdata_d = fifo_control_reg_q;
      `IDX_MODEM_CONTROL: rdata_d = modem_control_reg_q;
      `IDX_INTERRUPT_STATUS: rdata_d = {2'b00, xoff_flag_q, special_flag_q, 3'b000, !irq_d};
      `IDX_MODEM_STATUS: rdata_d = {modem_level, modem_delta_q}; // RULE16
      `IDX_SCRATCHPAD: rdata_d = scratchpad_reg_q;
      `IDX_TRIGGER_CONTROL: rdata_d = trigger_control_reg_q;
      `IDX_TRIGGER_LEVEL: rdata_d = trigger_level_reg_q;
      `IDX_DIVISOR_LOW: rdata_d = divisor_low_byte_q;
      `IDX_DIVISOR_HIGH: rdata_d = divisor_high_byte_q;
      `IDX_FRACTIONAL_DIVISOR: rdata_d = fractional_divisor_reg_q;
      `IDX_ENHANCED_FEATURE: rdata_d = enhanced_feature_control_q;
      `IDX_RESUME_CHAR_ONE: rdata_d = flow_resume_char_one_q;
      `IDX_RESUME_CHAR_TWO: rdata_d = flow_resume_char_two_q;
      `IDX_PAUSE_CHAR_ONE: rdata_d = flow_pause_char_one_q;
      `IDX_PAUSE_CHAR_TWO: rdata_d = flow_pause_char_two_q;
      `IDX_GPIO_CONTROL: rdata_d = gpio_control_reg_q;
      `IDX_LINE_STATUS: rdata_d = {1'b0, tx_empty_i, thr_empty_i, 4'h0, (rx_fill_i != {FILL_W{1'b0}})};
      default: rdata_d = 8'h00;
    endcase
  end

  // Registered outputs
  always @(posedge clk_i) begin
    if (any_reset) begin
      reg_rdata_o <= 8'h00;
      tx_o <= 1'b1; // RULE18
      tx_enable_o <= 1'b1;
      dtr_n_o <= 1'b1; // RULE18
      irq_n_o <= 1'b1; // RULE18
      soft_reset_o <= 1'b0;
      divisor_o <= {`RST_DIVISOR_HIGH, `RST_DIVISOR_LOW};
      fractional_divisor_o <= `RST_FRACTIONAL_DIVISOR;
    end else begin
      reg_rdata_o <= reg_rd_i ? rdata_d : reg_rdata_o;
      tx_o <= tx_serial_i;
      // Stalls between characters is left to the transmitter
      tx_enable_o <= !(enhanced_feature_control_q[`EFR_AUTO_CTS] && modem_sync_q[0]); // RULE12
      dtr_n_o <= !modem_control_reg_q[`MCR_DTR];
      irq_n_o <= !irq_d;
      soft_reset_o <= wr_hit && (reg_addr_i == `IDX_GPIO_CONTROL) && reg_wdata_i[`IOC_SOFT_RESET];
      divisor_o <= {divisor_high_byte_q, divisor_low_byte_q};
      fractional_divisor_o <= fractional_divisor_reg_q;
    end
  end
endmodule

// ===== bench/uart_eff_monitor.sv
`timescale 1ns/1ps
module uart_eff_monitor (
  // Clock and resets
  input wire clk_i,
  input wire reset_i,
  input wire por_i,
  // Register port
  input wire reg_wr_i,
  input wire [4:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  // Receive side
  input wire rx_char_valid_i,
  input wire [7:0] rx_char_i,
  input wire rx_store_o,
  input wire [7:0] rx_store_data_o,
  input wire xoff_event_o,
  // Pins and configuration
  input wire cts_n_i,
  input wire tx_o,
  input wire tx_enable_o,
  input wire rts_n_o,
  input wire dtr_n_o,
  input wire irq_n_o,
  input wire soft_reset_o,
  input wire [15:0] divisor_o,
  input wire [7:0] fractional_divisor_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i || por_i);

  property p_reset_pins;
    disable iff (1'b0) (reset_i || por_i) |=> (tx_o && rts_n_o && dtr_n_o && irq_n_o);
  endproperty
  a_reset_pins: assert property (p_reset_pins) else $error("outputs not idle after reset");
  property p_por_div;
    disable iff (1'b0) por_i |=> (divisor_o == 16'h0001 && fractional_divisor_o == 8'h00);
  endproperty
  a_por_div: assert property (p_por_div) else $error("divisor not at power-up value");
  property p_store_or_drop;
    rx_char_valid_i |=> (rx_store_o != xoff_event_o);
  endproperty
  a_store_or_drop: assert property (p_store_or_drop) else $error("character neither stored nor dropped");
  property p_store_data;
    rx_char_valid_i ##1 rx_store_o |-> rx_store_data_o == $past(rx_char_i);
  endproperty
  a_store_data: assert property (p_store_data) else $error("stored data differs from received");
  property p_no_spurious;
    !rx_char_valid_i |=> !rx_store_o && !xoff_event_o;
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("store or pause without a character");
  property p_cts_resume;
    (!cts_n_i) [*4] |-> tx_enable_o;
  endproperty
  a_cts_resume: assert property (p_cts_resume) else $error("transmit held while clear-to-send low");
  property p_soft_pulse;
    reg_wr_i && reg_addr_i == 5'h11 && reg_wdata_i[3] |=> soft_reset_o ##1 !soft_reset_o;
  endproperty
  a_soft_pulse: assert property (p_soft_pulse) else $error("software reset pulse wrong");
  property p_soft_pins;
    soft_reset_o |-> ##[1:2] (tx_o && rts_n_o && dtr_n_o && irq_n_o);
  endproperty
  a_soft_pins: assert property (p_soft_pins) else $error("outputs not idle after software reset");
  property p_xoff_irq;
    xoff_event_o |-> ##[1:3] !irq_n_o;
  endproperty
  a_xoff_irq: assert property (p_xoff_irq) else $error("pause character raised no interrupt");

  c_xoff: cover property (xoff_event_o);
  c_cts_stop: cover property (!tx_enable_o);
  c_rts_halt: cover property ($rose(rts_n_o));
endmodule

bind uart_enhanced_feature_flow_control uart_eff_monitor u_mon (
  .clk_i(clk_i), .reset_i(reset_i), .por_i(por_i), .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .rx_char_valid_i(rx_char_valid_i), .rx_char_i(rx_char_i),
  .rx_store_o(rx_store_o), .rx_store_data_o(rx_store_data_o), .xoff_event_o(xoff_event_o),
  .cts_n_i(cts_n_i), .tx_o(tx_o), .tx_enable_o(tx_enable_o), .rts_n_o(rts_n_o), .dtr_n_o(dtr_n_o),
  .irq_n_o(irq_n_o), .soft_reset_o(soft_reset_o), .divisor_o(divisor_o),
  .fractional_divisor_o(fractional_divisor_o)
);

// ===== bench/remote_serial_peer.sv
`timescale 1ns/1ps
module remote_serial_peer (
  // Clock
  input wire clk_i,
  // Peer receive space exhausted
  input wire busy_i,
  // Pin toward the device
  output reg cts_n_o
);
  initial cts_n_o = 1'b0;
  // Peer answers its own congestion one cycle late
  always @(posedge clk_i) begin
    cts_n_o <= busy_i;
  end
endmodule

// ===== bench/test_uart_enhanced_feature_flow_control.sv
`timescale 1ns/1ps
module test_uart_enhanced_feature_flow_control;
  typedef struct {logic [4:0] a; logic [7:0] r; logic [7:0] w; logic [7:0] e;} row_t;
  // Address, reset value, write value, read back; power-up-only rows first
  row_t rows [18] = '{'{5'h0d, 8'h00, 8'h5a, 8'h5a}, '{5'h0e, 8'h00, 8'ha5, 8'ha5},
    '{5'h0f, 8'h00, 8'h13, 8'h13}, '{5'h10, 8'h00, 8'h24, 8'h24}, '{5'h06, 8'hff, 8'h3c, 8'h3c},
    '{5'h09, 8'h01, 8'h07, 8'h07}, '{5'h0a, 8'h00, 8'h12, 8'h12}, '{5'h05, 8'hb0, 8'h00, 8'hb0},
    '{5'h01, 8'h00, 8'hff, 8'h0f}, '{5'h03, 8'h00, 8'h07, 8'h03}, '{5'h0b, 8'h00, 8'h0a, 8'h00},
    '{5'h07, 8'h0f, 8'h55, 8'h0f}, '{5'h13, 8'h00, 8'h77, 8'h00}, '{5'h04, 8'h01, 8'hff, 8'h01},
    '{5'h12, 8'h60, 8'hff, 8'h60}, '{5'h02, 8'h00, 8'h3f, 8'h0f}, '{5'h00, 8'h1d, 8'h03, 8'h03},
    '{5'h08, 8'h00, 8'h30, 8'h00}};
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic por_i = 1'b1;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [4:0] reg_addr_i = 5'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [7:0] rx_char_i = 8'h00;
  logic rx_char_valid_i = 1'b0;
  logic tx_serial_i = 1'b1;
  logic busy = 1'b0;
  logic dsr_n = 1'b0;
  logic [6:0] rx_fill_i = 7'h00;
  wire cts_n;
  wire [7:0] reg_rdata_o;
  wire [7:0] rx_store_data_o;
  wire [7:0] fractional_divisor_o;
  wire [15:0] divisor_o;
  wire rx_store_o, xoff_event_o, tx_o, tx_enable_o, rts_n_o, dtr_n_o, irq_n_o, soft_reset_o;
  int mismatches = 0;
  int checks = 0;
  int cycles = 0;

  always #2 clk_i = ~clk_i;

  uart_enhanced_feature_flow_control #(.FILL_W(7)) u_dut (
    .clk_i(clk_i), .reset_i(reset_i), .por_i(por_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .rx_char_valid_i(rx_char_valid_i), .rx_char_i(rx_char_i), .rx_fill_i(rx_fill_i),
    .rx_store_o(rx_store_o), .rx_store_data_o(rx_store_data_o), .xoff_event_o(xoff_event_o),
    .tx_serial_i(tx_serial_i), .tx_empty_i(1'b1), .thr_empty_i(1'b1), .tx_o(tx_o),
    .tx_enable_o(tx_enable_o), .cts_n_i(cts_n), .dsr_n_i(dsr_n), .ri_n_i(1'b1), .cd_n_i(1'b0),
    .rts_n_o(rts_n_o), .dtr_n_o(dtr_n_o), .irq_n_o(irq_n_o), .soft_reset_o(soft_reset_o),
    .divisor_o(divisor_o), .fractional_divisor_o(fractional_divisor_o)
  );
  remote_serial_peer u_peer (.clk_i(clk_i), .busy_i(busy), .cts_n_o(cts_n));

  task final_report;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      final_report();
    end
  end

  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task rd(input logic [4:0] a, input logic [7:0] e);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 chk(16'(reg_rdata_o), 16'(e));
  endtask
  // Store and pause flags are single-cycle pulses, so they are looked at in that cycle
  task chr(input logic [7:0] c, input logic st, input logic xo);
    @(posedge clk_i);
    rx_char_valid_i <= 1'b1;
    rx_char_i <= c;
    @(posedge clk_i);
    rx_char_valid_i <= 1'b0;
    #1 chk(16'({rx_store_o, xoff_event_o}), 16'({st, xo}));
    if (st) chk(16'(rx_store_data_o), 16'(c));
  endtask
  task fill(input logic [6:0] f, input logic rn, input logic iq);
    @(posedge clk_i);
    rx_fill_i <= f;
    repeat (3) @(posedge clk_i);
    #1 chk(16'({rts_n_o, irq_n_o}), 16'({rn, iq}));
  endtask
  task pulse_reset(input logic p);
    @(posedge clk_i);
    reset_i <= 1'b1;
    por_i <= p;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    por_i <= 1'b0;
  endtask

  initial begin
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    por_i <= 1'b0;
    foreach (rows[i]) begin
      rd(rows[i].a, rows[i].r);
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, rows[i].e);
    end
    chk(divisor_o, 16'h1207);
    chk(16'({rts_n_o, dtr_n_o}), 16'h0);
    pulse_reset(1'b0);
    #1 chk(16'({tx_o, rts_n_o, dtr_n_o, irq_n_o}), 16'hf);
    for (int i = 0; i < 7; i++) rd(rows[i].a, rows[i].e);
    rd(5'h01, 8'h00);
    chk(divisor_o, 16'h1207);
    // Enhanced gate, then latch with the enable cleared
    wr(5'h0c, 8'h10);
    wr(5'h01, 8'hff);
    rd(5'h01, 8'hff);
    wr(5'h0b, 8'h0a);
    @(posedge clk_i);
    #1 chk(16'(fractional_divisor_o), 16'h0a);
    wr(5'h07, 8'h28);
    wr(5'h0c, 8'h00);
    wr(5'h01, 8'h00);
    rd(5'h01, 8'hf0);
    rd(5'h07, 8'h28);
    wr(5'h0c, 8'h30);
    chr(8'h24, 1'b1, 1'b0);
    rd(5'h04, 8'h10);
    chr(8'h25, 1'b1, 1'b0);
    wr(5'h0c, 8'h32);
    chr(8'h24, 1'b1, 1'b0);
    rd(5'h04, 8'h10);
    wr(5'h0c, 8'h30);
    wr(5'h0c, 8'h31);
    chr(8'h24, 1'b0, 1'b1);
    repeat (2) @(posedge clk_i);
    rd(5'h04, 8'h30);
    rd(5'h04, 8'h01);
    // Request-to-send by hand, then under automatic control
    wr(5'h0c, 8'h10);
    wr(5'h03, 8'h00);
    fill(7'd0, 1'b1, 1'b1);
    wr(5'h03, 8'h02);
    fill(7'd0, 1'b0, 1'b1);
    wr(5'h03, 8'h00);
    wr(5'h0c, 8'h50);
    fill(7'd0, 1'b1, 1'b1);
    wr(5'h03, 8'h02);
    fill(7'd0, 1'b0, 1'b1);
    wr(5'h01, 8'hf1);
    fill(7'd7, 1'b0, 1'b1);
    fill(7'd8, 1'b0, 1'b0);
    fill(7'd31, 1'b0, 1'b0);
    fill(7'd32, 1'b1, 1'b0);
    fill(7'd8, 1'b1, 1'b0);
    fill(7'd7, 1'b0, 1'b1);
    // Nonzero trigger level register overrides the fifo control table
    wr(5'h08, 8'h30);
    fill(7'd12, 1'b0, 1'b0);
    fill(7'd11, 1'b0, 1'b1);
    // Clear-to-send
    @(posedge clk_i) busy <= 1'b1;
    tx_serial_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    #1 chk(16'({tx_enable_o, tx_o}), 16'h2);
    wr(5'h0c, 8'hd0);
    repeat (4) @(posedge clk_i);
    #1 chk(16'(tx_enable_o), 16'h0);
    @(posedge clk_i) busy <= 1'b0;
    repeat (5) @(posedge clk_i);
    #1 chk(16'(tx_enable_o), 16'h1);
    // Modem change flags: clear-to-send toggled above, data-set-ready now
    @(posedge clk_i) dsr_n <= 1'b1;
    repeat (3) @(posedge clk_i);
    rd(5'h05, 8'h93);
    rd(5'h05, 8'h90);
    // Software reset keeps power-up-only contents
    wr(5'h03, 8'h03);
    wr(5'h11, 8'h08);
    repeat (3) @(posedge clk_i);
    rd(5'h0d, 8'h5a);
    rd(5'h0c, 8'h00);
    rd(5'h03, 8'h00);
    pulse_reset(1'b1);
    rd(5'h0d, 8'h00);
    chk(divisor_o, 16'h0001);
    final_report();
  end
endmodule
